// ### core/limits_pkg.sv
// Register map, field layout and scaling constants for the limit and readback bank
package limits_pkg;

    // Command codes
    localparam logic [7:0] CMD_ADC_BUS_SYSPWR = 8'h23;
    localparam logic [7:0] CMD_ADC_BAT_CURR  = 8'h24;
    localparam logic [7:0] CMD_SRC_VOLT_LIM  = 8'h3B;
    localparam logic [7:0] CMD_SRC_CURR_LIM  = 8'h3C;

    // Reset values
    localparam logic [7:0] SRC_VOLT_RESET    = 8'h00;
    localparam logic [6:0] SRC_CURR_RESET    = 7'h00;

    // Voltage limit field: bits 13..6, reserved-high 15..14, ignored 5..0
    localparam int VOLT_FIELD_LSB            = 6;
    localparam int VOLT_FIELD_MSB            = 13;
    localparam int VOLT_RSVD_HI_LSB          = 14;
    localparam logic [14:0] VOLT_OFFSET_MV   = 15'h1180;
    localparam int VOLT_LSB_MV               = 64;

    // Current limit field: bits 14..8, reserved-high 15, ignored 7..0
    localparam int CURR_FIELD_LSB            = 8;
    localparam int CURR_FIELD_MSB            = 14;
    localparam int CURR_RSVD_HI_BIT          = 15;
    localparam logic [12:0] CURR_LSB_MA      = 13'h0032;

    // Readback scaling (per count, and the bus voltage zero point)
    localparam int BUS_VOLT_LSB_MV           = 64;
    localparam int BUS_VOLT_ZERO_MV          = 3200;
    localparam int SYS_PWR_LSB_MV            = 12;
    localparam int CHG_CURR_LSB_MA           = 64;
    localparam int DCHG_CURR_LSB_MA          = 256;

    // Bus address, value is arbitrary
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h09;

    // Byte positions inside a transaction
    localparam logic [1:0] BYTE_ADDR         = 2'h0;
    localparam logic [1:0] BYTE_CMD          = 2'h1;
    localparam logic [1:0] BYTE_LO           = 2'h2;
    localparam logic [1:0] BYTE_HI           = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b011,
        ST_TX   = 3'b010,
        ST_MACK = 3'b110
    } bus_state_t;

endpackage

// ### core/source_limits_regs.sv
// Two-wire slave with source-mode limit registers and packed ADC readback words
module source_limits_regs #(
    parameter logic [6:0] SLAVE_ADDR = limits_pkg::SLAVE_ADDR_DEFAULT
) (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [7:0]  adc_bus_voltage_i,
    input  wire logic [7:0]  adc_system_power_i,
    input  wire logic [6:0]  adc_charge_current_i,
    input  wire logic [6:0]  adc_discharge_current_i,
    output logic [7:0]       volt_limit_code_o,
    output logic [14:0]      volt_limit_mv_o,
    output logic [6:0]       curr_limit_code_o,
    output logic [12:0]      curr_limit_ma_o,
    output logic             invalid_write_o
);

    // Pin synchronisers, then one more stage for edge detection
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_prev_q;
    logic       sda_prev_q;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    wire scl_s     = scl_sync_q[1];
    wire sda_s     = sda_sync_q[1];
    wire scl_rise  = scl_s & ~scl_prev_q;
    wire scl_fall  = ~scl_s & scl_prev_q;
    wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    limits_pkg::bus_state_t state_q;
    limits_pkg::bus_state_t state_d;
    logic [7:0]  shift_q;
    logic [7:0]  shift_d;
    logic [3:0]  bit_cnt_q;
    logic [3:0]  bit_cnt_d;
    logic [1:0]  byte_idx_q;
    logic [1:0]  byte_idx_d;
    logic        read_q;
    logic        read_d;
    logic        hi_sent_q;
    logic        hi_sent_d;
    logic        mack_q;
    logic        mack_d;
    logic        oe_q;
    logic        oe_d;
    logic [7:0]  cmd_q;
    logic [7:0]  cmd_d;
    logic [7:0]  lo_q;
    logic [7:0]  lo_d;
    logic [7:0]  tx_hi_q;
    logic [7:0]  tx_hi_d;
    logic        commit;

    logic [7:0]  volt_code_q;
    logic [14:0] volt_mv_q;
    logic [6:0]  curr_code_q;
    logic [12:0] curr_ma_q;
    logic        invalid_q;

    // Packed readback words
    wire [15:0] adc_bus_word = {adc_bus_voltage_i, adc_system_power_i};
    wire [15:0] adc_bat_word = {1'b0, adc_charge_current_i,
                                1'b0, adc_discharge_current_i};
    wire [15:0] volt_word    = {2'b00, volt_code_q, 6'h00};
    wire [15:0] curr_word    = {1'b0, curr_code_q, 8'h00};

    // Read mux; unmapped commands read as zero. Words passed in so the mux follows the ADC
    function automatic logic [15:0] read_word(input logic [7:0]  cmd,
                                              input logic [15:0] bus_w, input logic [15:0] bat_w,
                                              input logic [15:0] vlt_w, input logic [15:0] cur_w);
        case (cmd)
            limits_pkg::CMD_ADC_BUS_SYSPWR: read_word = bus_w;
            limits_pkg::CMD_ADC_BAT_CURR:   read_word = bat_w;
            limits_pkg::CMD_SRC_VOLT_LIM:   read_word = vlt_w;
            limits_pkg::CMD_SRC_CURR_LIM:   read_word = cur_w;
            default:                        read_word = 16'h0000;
        endcase
    endfunction

    wire [15:0] rd_word  = read_word(cmd_q, adc_bus_word, adc_bat_word, volt_word, curr_word);
    wire [15:0] wr_word  = {shift_q, lo_q};
    wire        addr_hit = (shift_q[7:1] == SLAVE_ADDR);

    // Reserved-high check and field extraction
    wire volt_bad = |wr_word[15:limits_pkg::VOLT_RSVD_HI_LSB];
    wire curr_bad = wr_word[limits_pkg::CURR_RSVD_HI_BIT];
    wire [7:0] volt_field =
        wr_word[limits_pkg::VOLT_FIELD_MSB:limits_pkg::VOLT_FIELD_LSB];
    wire [6:0] curr_field =
        wr_word[limits_pkg::CURR_FIELD_MSB:limits_pkg::CURR_FIELD_LSB];
    wire is_volt = (cmd_q == limits_pkg::CMD_SRC_VOLT_LIM);
    wire is_curr = (cmd_q == limits_pkg::CMD_SRC_CURR_LIM);

    // Scaled limits for the converter
    wire [14:0] volt_mv_next = limits_pkg::VOLT_OFFSET_MV
                             + {1'b0, volt_field, 6'h00};
    wire [12:0] curr_ma_next = 13'({6'h00, curr_field} * limits_pkg::CURR_LSB_MA);

    always_comb begin
        state_d    = state_q;
        shift_d    = shift_q;
        bit_cnt_d  = bit_cnt_q;
        byte_idx_d = byte_idx_q;
        read_d     = read_q;
        hi_sent_d  = hi_sent_q;
        mack_d     = mack_q;
        oe_d       = oe_q;
        cmd_d      = cmd_q;
        lo_d       = lo_q;
        tx_hi_d    = tx_hi_q;
        commit     = 1'b0;
        if (start_det) begin
            state_d    = limits_pkg::ST_RX;
            bit_cnt_d  = 4'h0;
            byte_idx_d = limits_pkg::BYTE_ADDR;
            hi_sent_d  = 1'b0;
            oe_d       = 1'b0;
        end else if (stop_det) begin
            state_d = limits_pkg::ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            unique case (state_q)
                limits_pkg::ST_IDLE: begin
                end
                limits_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt_q != 4'h8) begin
                        shift_d   = {shift_q[6:0], sda_s};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        state_d = limits_pkg::ST_ACK;
                        oe_d    = 1'b1;
                        unique case (byte_idx_q)
                            limits_pkg::BYTE_ADDR: begin
                                read_d = shift_q[0];
                                if (!addr_hit) begin
                                    state_d = limits_pkg::ST_IDLE;
                                    oe_d    = 1'b0;
                                end
                            end
                            limits_pkg::BYTE_CMD: cmd_d = shift_q;
                            limits_pkg::BYTE_LO:  lo_d  = shift_q;
                            limits_pkg::BYTE_HI:  commit = ~hi_sent_q;
                        endcase
                    end
                end
                limits_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_d = 4'h0;
                        if (byte_idx_q == limits_pkg::BYTE_ADDR && read_q) begin
                            // Whole word captured at once so both bytes agree
                            state_d   = limits_pkg::ST_TX;
                            shift_d   = rd_word[7:0];
                            tx_hi_d   = rd_word[15:8];
                            hi_sent_d = 1'b0;
                            oe_d      = ~rd_word[7];
                        end else begin
                            // Extra bytes past the high byte are acked and dropped
                            state_d    = limits_pkg::ST_RX;
                            oe_d       = 1'b0;
                            if (byte_idx_q != limits_pkg::BYTE_HI) begin
                                byte_idx_d = byte_idx_q + 2'h1;
                            end else begin
                                hi_sent_d = 1'b1;
                            end
                        end
                    end
                end
                limits_pkg::ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            state_d = limits_pkg::ST_MACK;
                            oe_d    = 1'b0;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d    = ~shift_q[6];
                        end
                    end
                end
                limits_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        mack_d = ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_q && !hi_sent_q) begin
                            state_d   = limits_pkg::ST_TX;
                            shift_d   = tx_hi_q;
                            hi_sent_d = 1'b1;
                            bit_cnt_d = 4'h0;
                            oe_d      = ~tx_hi_q[7];
                        end else begin
                            state_d = limits_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = limits_pkg::ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q    <= limits_pkg::ST_IDLE;
            shift_q    <= 8'h00;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= 2'h0;
            read_q     <= 1'b0;
            hi_sent_q  <= 1'b0;
            mack_q     <= 1'b0;
            oe_q       <= 1'b0;
            cmd_q      <= 8'h00;
            lo_q       <= 8'h00;
            tx_hi_q    <= 8'h00;
        end else begin
            state_q    <= state_d;
            shift_q    <= shift_d;
            bit_cnt_q  <= bit_cnt_d;
            byte_idx_q <= byte_idx_d;
            read_q     <= read_d;
            hi_sent_q  <= hi_sent_d;
            mack_q     <= mack_d;
            oe_q       <= oe_d;
            cmd_q      <= cmd_d;
            lo_q       <= lo_d;
            tx_hi_q    <= tx_hi_d;
        end
    end

    // Limit registers; invalid words leave the old limit in force
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            volt_code_q <= limits_pkg::SRC_VOLT_RESET;
            volt_mv_q   <= limits_pkg::VOLT_OFFSET_MV;
            curr_code_q <= limits_pkg::SRC_CURR_RESET;
            curr_ma_q   <= 13'h0000;
            invalid_q   <= 1'b0;
        end else begin
            invalid_q <= commit && ((is_volt && volt_bad) || (is_curr && curr_bad));
            if (commit && is_volt && !volt_bad) begin
                volt_code_q <= volt_field;
                volt_mv_q   <= volt_mv_next;
            end
            if (commit && is_curr && !curr_bad) begin
                curr_code_q <= curr_field;
                curr_ma_q   <= curr_ma_next;
            end
        end
    end

    // Open-drain: data line only ever pulled low
    assign sda_o             = 1'b0;
    assign sda_oe_o          = oe_q;
    assign volt_limit_code_o = volt_code_q;
    assign volt_limit_mv_o   = volt_mv_q;
    assign curr_limit_code_o = curr_code_q;
    assign curr_limit_ma_o   = curr_ma_q;
    assign invalid_write_o   = invalid_q;

endmodule

// ### verification/source_limits_regs_chk.sv
// Port checker for the limit and readback bank
module source_limits_regs_chk (
    input wire logic        ref_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        scl_i,
    input wire logic        sda_oe_o,
    input wire logic [7:0]  volt_limit_code_o,
    input wire logic [14:0] volt_limit_mv_o,
    input wire logic [6:0]  curr_limit_code_o,
    input wire logic [12:0] curr_limit_ma_o,
    input wire logic        invalid_write_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence limits_steady;
        $stable(volt_limit_code_o) && $stable(curr_limit_code_o);
    endsequence
    a_volt_mv_sum: assert property (
        volt_limit_mv_o == 15'h1180 + 15'(volt_limit_code_o) * 15'h0040)
        else $error("voltage limit mv off");
    a_curr_ma_sum: assert property (
        curr_limit_ma_o == 13'(curr_limit_code_o) * 13'h0032)
        else $error("current limit ma off");
    a_invalid_one_cycle: assert property (
        invalid_write_o |=> !invalid_write_o)
        else $error("invalid pulse too long");
    a_invalid_keeps_limits: assert property (
        invalid_write_o |-> limits_steady ##1 limits_steady)
        else $error("rejected write changed a limit");
    a_volt_change_valid: assert property (
        $changed(volt_limit_code_o) |-> !invalid_write_o && !$past(scl_i, 2))
        else $error("voltage code changed badly");
    a_curr_change_valid: assert property (
        $changed(curr_limit_code_o) |-> !invalid_write_o && !$past(scl_i, 2))
        else $error("current code changed badly");
    a_data_steady_high: assert property (
        scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data moved while clock high");
    a_reset_zero: assert property (
        $fell(sys_rst_i) |-> volt_limit_code_o == 8'h00 && curr_limit_code_o == 7'h00)
        else $error("limits not zero after reset");
endmodule
bind source_limits_regs source_limits_regs_chk i_source_limits_regs_chk (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .volt_limit_code_o(volt_limit_code_o), .volt_limit_mv_o(volt_limit_mv_o),
    .curr_limit_code_o(curr_limit_code_o), .curr_limit_ma_o(curr_limit_ma_o),
    .invalid_write_o(invalid_write_o)
);

// ### verification/smbus_host_model.sv
// Two-wire bus host model: drives the clock, pulls the data line
module smbus_host_model (
    input  wire logic ref_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Halves of 8 clocks, twice the slave's minimum
    task automatic bit_io(input logic b, output logic s);
        tick(4);
        sda_pull_o <= ~b;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        s = sda_i;
        tick(4);
        scl_o <= 1'b0;
    endtask
    task automatic start_cond();
        tick(4);
        sda_pull_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_pull_o <= 1'b1;
        tick(8);
        scl_o <= 1'b0;
    endtask
    task automatic stop_cond();
        tick(4);
        sda_pull_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_pull_o <= 1'b0;
        tick(8);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ab,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, ack);
    endtask
    // Reserved bits come from the caller; refusal cases set them
    task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                              input logic [15:0] w, output logic nak);
        logic [7:0] q;
        logic [3:0] a;
        start_cond();
        byte_io({adr, 1'b0}, 1'b1, q, a[0]);
        byte_io(cmd, 1'b1, q, a[1]);
        byte_io(w[7:0], 1'b1, q, a[2]);
        byte_io(w[15:8], 1'b1, q, a[3]);
        stop_cond();
        nak = |a;
    endtask
    task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd,
                             output logic [15:0] w, output logic nak);
        logic [7:0] q;
        logic [3:0] a;
        start_cond();
        byte_io({adr, 1'b0}, 1'b1, q, a[0]);
        byte_io(cmd, 1'b1, q, a[1]);
        start_cond();
        byte_io({adr, 1'b1}, 1'b1, q, a[2]);
        byte_io(8'hFF, 1'b0, w[7:0], a[3]);
        byte_io(8'hFF, 1'b1, w[15:8], a[3]);
        stop_cond();
        nak = a[0] | a[1] | a[2];
    endtask
endmodule

// ### verification/source_limits_regs_tb_top.sv
// Self-checking bench for the limit and readback bank
module source_limits_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] ADR = limits_pkg::SLAVE_ADDR_DEFAULT;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        scl;
    logic        sda_pull;
    logic        sda_line;
    logic        sda_o;
    logic        sda_oe_o;
    logic        invalid_write_o;
    logic [7:0]  adc_bus_voltage_i = 8'h00;
    logic [7:0]  adc_system_power_i = 8'h00;
    logic [6:0]  adc_charge_current_i = 7'h00;
    logic [6:0]  adc_discharge_current_i = 7'h00;
    logic [7:0]  volt_limit_code_o;
    logic [14:0] volt_limit_mv_o;
    logic [6:0]  curr_limit_code_o;
    logic [12:0] curr_limit_ma_o;
    int          err_total = 0;
    int          total_checks = 0;
    int          inv_seen = 0;
    // Pulled-up wire, low while either party pulls
    assign sda_line = ~(sda_pull | (sda_oe_o & ~sda_o));
    always #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (invalid_write_o === 1'b1) inv_seen <= inv_seen + 1;
    end
    source_limits_regs i_source_limits_regs (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .adc_bus_voltage_i(adc_bus_voltage_i), .adc_system_power_i(adc_system_power_i),
        .adc_charge_current_i(adc_charge_current_i),
        .adc_discharge_current_i(adc_discharge_current_i),
        .volt_limit_code_o(volt_limit_code_o), .volt_limit_mv_o(volt_limit_mv_o),
        .curr_limit_code_o(curr_limit_code_o), .curr_limit_ma_o(curr_limit_ma_o),
        .invalid_write_o(invalid_write_o)
    );
    smbus_host_model i_smbus_host_model (
        .ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] w);
        logic nak;
        i_smbus_host_model.write_word(ADR, c, w, nak);
        check(16'(nak), 16'h0000);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] w;
        logic nak;
        i_smbus_host_model.read_word(ADR, c, w, nak);
        check(16'(nak), 16'h0000);
        check(w, exp);
    endtask
    task automatic lim(input logic [7:0] vc, input logic [6:0] cc);
        check(16'(volt_limit_code_o), 16'(vc));
        check(16'(volt_limit_mv_o), 16'h1180 + 16'(vc) * 16'h0040);
        check(16'(curr_limit_code_o), 16'(cc));
        check(16'(curr_limit_ma_o), 16'(cc) * 16'h0032);
    endtask
    task automatic t_reset();
        lim(8'h00, 7'h00);
        rd(8'h3B, 16'h0000);
        rd(8'h3C, 16'h0000);
    endtask
    task automatic t_limits();
        wr(8'h3B, 16'h3FC0);
        lim(8'hFF, 7'h00);
        wr(8'h3B, 16'h157F);
        lim(8'h55, 7'h00);
        rd(8'h3B, 16'h1540);
        wr(8'h3C, 16'h7FFF);
        lim(8'h55, 7'h7F);
        rd(8'h3C, 16'h7F00);
        wr(8'h3C, 16'h01FF);
        lim(8'h55, 7'h01);
    endtask
    task automatic t_invalid();
        logic [7:0]  cmd [3] = '{8'h3B, 8'h3B, 8'h3C};
        logic [15:0] val [3] = '{16'h8040, 16'h4FFF, 16'hFF00};
        for (int i = 0; i < 3; i++) begin
            wr(cmd[i], val[i]);
            check(16'(inv_seen), 16'(i + 1));
            lim(8'h55, 7'h01);
        end
    endtask
    task automatic t_adc();
        logic nak;
        @(posedge ref_clk_i);
        adc_bus_voltage_i <= 8'hA5;
        adc_system_power_i <= 8'h3C;
        adc_charge_current_i <= 7'h55;
        adc_discharge_current_i <= 7'h2A;
        rd(8'h23, 16'hA53C);
        rd(8'h24, 16'h552A);
        wr(8'h23, 16'hFFFF);
        wr(8'h24, 16'hFFFF);
        rd(8'h24, 16'h552A);
        lim(8'h55, 7'h01);
        rd(8'h50, 16'h0000);
        i_smbus_host_model.write_word(ADR ^ 7'h01, 8'h3B, 16'h0000, nak);
        check(16'(nak), 16'h0001);
        lim(8'h55, 7'h01);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        t_reset();
        t_limits();
        t_invalid();
        t_adc();
        end_sim();
    end
    // About 20 transfers of some 700 clocks each
    initial begin
        #2000000;
        err_total++;
        end_sim();
    end
endmodule
